// *** bench/sagc_partner.sv ***
// Behavioural model of the two processors and the DMA engine.
// Assumes the bench changes its commands at falling edges of clk_in.
`timescale 1ns/1ps
`default_nettype none

module sagc_partner (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    // Commands from the bench, bus hold from the block
    input  wire logic [1:0]            sleep_cmd_in,
    input  wire logic [1:0]            wake_cmd_in,
    input  wire logic                  dma_busy_in,
    input  wire logic                  bus_hold_in,
    // Status towards the block, bus access towards the bench
    output var sagc_pkg::sagc_status_t status_out,
    output logic                       bus_access_out
);
    logic [1:0] asleep_r;
    logic [1:0] irq_r;
    logic       dma_r;

    // Cores sleep on a wait instruction; a wake event rouses both, so no core is left asleep
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            asleep_r <= 2'h0;
            irq_r    <= 2'h0;
            dma_r    <= 1'h0;
        end else begin
            asleep_r <= (|wake_cmd_in) ? 2'h0 : (asleep_r | sleep_cmd_in);
            irq_r    <= wake_cmd_in & asleep_r;
            dma_r    <= dma_busy_in;
        end
    end

    // Status fields in struct order
    assign status_out     = {asleep_r, irq_r, dma_r};
    // Cores reach for the bus only while awake and not held off
    assign bus_access_out = ~bus_hold_in & ~(|asleep_r);
endmodule
`default_nettype wire

// *** bench/sleep_aware_clock_gating_bench.sv ***
// Self-checking bench for the sleep aware clock gating block.
// Assumes the partner model supplies processor and DMA status.
`timescale 1ns/1ps
`default_nettype none

module sleep_aware_clock_gating_bench;
    logic                    clk_in;
    logic                    reset_in;
    sagc_pkg::sagc_status_t  status;
    sagc_pkg::sagc_mask_wr_t awake_wr;
    sagc_pkg::sagc_mask_wr_t sleep_wr;
    logic [1:0]              sleep_cmd;
    logic [1:0]              wake_cmd;
    logic                    dma_busy;
    logic                    bus_hold;
    logic                    bus_access;
    logic                    in_sleep;
    sagc_pkg::sagc_mask_t    awake_mask;
    sagc_pkg::sagc_mask_t    sleep_mask;
    sagc_pkg::sagc_mask_t    active;
    logic [7:0]              gclk;
    int                      mismatches;
    int                      samples_checked;

    sagc_clock_gating DUT (.clk_in(clk_in), .reset_in(reset_in), .status_in(status), .awake_wr_in(awake_wr),
        .sleep_wr_in(sleep_wr), .bus_hold_out(bus_hold), .in_sleep_out(in_sleep),
        .awake_clock_mask_out(awake_mask), .sleep_clock_mask_out(sleep_mask), .active_mask_out(active),
        .gclk_out(gclk));
    sagc_partner cores (.clk_in(clk_in), .reset_in(reset_in), .sleep_cmd_in(sleep_cmd), .wake_cmd_in(wake_cmd),
        .dma_busy_in(dma_busy), .bus_hold_in(bus_hold), .status_out(status), .bus_access_out(bus_access));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Gated clocks low in the low phase, high only where enabled; ends on a falling edge
    task automatic chk_gclk(input logic [7:0] exp);
        #1;
        chk(gclk, 8'h00);
        @(posedge clk_in);
        #5;
        chk(gclk, exp);
        @(negedge clk_in);
    endtask

    // One-cycle load strobes, both sets in the same cycle allowed
    task automatic load(input logic al, input logic [7:0] av, input logic sl, input logic [7:0] sv);
        awake_wr = {al, av};
        sleep_wr = {sl, sv};
        @(negedge clk_in);
        awake_wr.load = 1'b0;
        sleep_wr.load = 1'b0;
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Both awake masks keep endpoints 3 and 4, the fabric and memories, running
    task automatic t_masks;
        load(1'b1, 8'h5A, 1'b0, 8'h00);
        chk(awake_mask, 8'h5A);
        @(negedge clk_in);
        chk(active, 8'h5A);
        chk_gclk(8'h5A);
        load(1'b1, 8'h3C, 1'b1, 8'hC3);
        chk(awake_mask, 8'h3C);
        chk(sleep_mask, 8'hC3);
        @(negedge clk_in);
        chk(active, 8'h3C);
        chk_gclk(8'h3C);
    endtask

    // One core asleep, then DMA busy, must not sleep; idle DMA then sleeps
    task automatic t_sleep(input logic [7:0] smask);
        sleep_cmd = 2'h1;
        @(negedge clk_in);
        sleep_cmd = 2'h0;
        repeat (4) begin
            chk(in_sleep, 1'b0);
            @(negedge clk_in);
        end
        sleep_cmd = 2'h2;
        dma_busy  = 1'b1;
        @(negedge clk_in);
        sleep_cmd = 2'h0;
        repeat (4) begin
            chk(in_sleep, 1'b0);
            @(negedge clk_in);
        end
        dma_busy = 1'b0;
        repeat (2) @(negedge clk_in);
        chk(in_sleep, 1'b1);
        @(negedge clk_in);
        chk(active, smask);
        chk_gclk(smask);
    endtask

    task automatic t_wake(input int core);
        wake_cmd[core] = 1'b1;
        @(negedge clk_in);
        wake_cmd = 2'h0;
        @(negedge clk_in);
        chk(in_sleep, 1'b0);
        chk(bus_hold, 1'b1);
        chk(bus_access, 1'b0);
        @(negedge clk_in);
        chk(active, 8'h3C);
        chk(bus_hold, 1'b1);
        @(negedge clk_in);
        chk(bus_hold, 1'b0);
    endtask

    // Free-running system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Watchdog at 2000 cycles, far beyond the roughly 50 cycles the sequence needs
    initial begin
        #80000;
        mismatches++;
        give_verdict();
    end

    // Main sequence
    initial begin
        mismatches = 0;
        samples_checked = 0;
        reset_in = 1'b1;
        awake_wr = '0;
        sleep_wr = '0;
        sleep_cmd = 2'h0;
        wake_cmd = 2'h0;
        dma_busy = 1'b0;
        repeat (6) @(negedge clk_in);
        chk(active, 8'hFF);
        reset_in = 1'b0;
        @(negedge clk_in);
        chk(awake_mask, 8'hFF);
        chk(sleep_mask, 8'hFF);
        chk({in_sleep, bus_hold}, 8'h00);
        t_masks();
        t_sleep(8'hC3);
        load(1'b0, 8'h00, 1'b1, 8'h81);
        @(negedge clk_in);
        chk(active, 8'h81);
        t_wake(0);
        t_sleep(8'h81);
        t_wake(1);
        give_verdict();
    end
endmodule
`default_nettype wire

// *** design/sagc_clock_gating.sv ***
// Top of the sleep aware clock gating block: mask sets, sleep tracking,
// wake stall and one gate per clock endpoint.
// Assumes processor and DMA status are synchronous to clk_in.
//
// Function
// RULE1: Each endpoint clock can be switched off on its own at any time by its enable flag.
// RULE2: Turning an endpoint gate on or off never makes a runt pulse on its clock.
// RULE3: Gating an endpoint off and on again leaves its state untouched, with no reset.
// RULE4: There are two mask sets of the same layout with one flag per endpoint.
// RULE5: Outside sleep the awake mask chooses which endpoints run.
// RULE6: Sleep is entered only when both processors are asleep and the DMA is idle.
// RULE7: Sleep is left as soon as either processor takes a wake interrupt.
// RULE8: During sleep every gate follows the sleep mask instead.
// RULE9: The two masks are independent and no consistency is forced between them.
// RULE10: On wake the processors are held off the bus until the clocks run again.
// RULE11: The processor clocks are not gated here; each processor gates its own.
// RULE12: Software should keep the bus fabric, stack and vector memories on in the awake mask.
// RULE13: Both masks reset to all ones so every clock runs after reset.
`timescale 1ns/1ps
`default_nettype none

module sagc_clock_gating (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    // Processor and DMA status
    input  wire sagc_pkg::sagc_status_t status_in,
    // Mask loads
    input  wire sagc_pkg::sagc_mask_wr_t awake_wr_in,
    input  wire sagc_pkg::sagc_mask_wr_t sleep_wr_in,
    // Bus stall towards the processors
    output logic                       bus_hold_out,
    // Status
    output logic                       in_sleep_out,
    output sagc_pkg::sagc_mask_t       awake_clock_mask_out,
    output sagc_pkg::sagc_mask_t       sleep_clock_mask_out,
    output sagc_pkg::sagc_mask_t       active_mask_out,
    // Gated endpoint clocks
    output logic [sagc_pkg::ENDPOINTS-1:0] gclk_out
);

    // ********************************
    // Mask sets
    // ********************************
    sagc_pkg::sagc_mask_t awake_clock_mask_r;
    sagc_pkg::sagc_mask_t sleep_clock_mask_r;
    sagc_pkg::sagc_mask_t awake_clock_mask_nxt;
    sagc_pkg::sagc_mask_t sleep_clock_mask_nxt;

    // Each set loads on its own strobe; nothing ties one to the other RULE9
    assign awake_clock_mask_nxt = awake_wr_in.load ? awake_wr_in.value : awake_clock_mask_r;
    assign sleep_clock_mask_nxt = sleep_wr_in.load ? sleep_wr_in.value : sleep_clock_mask_r;

    // Two identical sets, all clocks on out of reset RULE4 RULE13
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            awake_clock_mask_r <= sagc_pkg::MASK_RESET;
            sleep_clock_mask_r <= sagc_pkg::MASK_RESET;
        end else begin
            awake_clock_mask_r <= awake_clock_mask_nxt;
            sleep_clock_mask_r <= sleep_clock_mask_nxt;
        end
    end

    // ********************************
    // Sleep state tracking
    // ********************************
    sagc_pkg::sagc_state_t state_r;
    sagc_pkg::sagc_state_t state_nxt;
    logic [1:0]            hold_cnt_r;
    logic [1:0]            hold_cnt_nxt;
    wire                   sleep_ok;
    wire                   wake_req;

    // Only the sleep status of both cores and DMA idleness matter RULE6
    assign sleep_ok = (&status_in.proc_asleep) & ~status_in.dma_busy;
    // Either core's interrupt is enough to wake RULE7
    assign wake_req = |status_in.proc_wake_irq;

    // Wake beats a sleep request seen in the same cycle
    always_comb begin
        state_nxt    = state_r;
        hold_cnt_nxt = hold_cnt_r;
        unique case (state_r)
            sagc_pkg::SAGC_AWAKE: begin
                if (sleep_ok && !wake_req) begin
                    state_nxt = sagc_pkg::SAGC_SLEEP; // RULE6
                end
            end
            sagc_pkg::SAGC_SLEEP: begin
                if (wake_req) begin
                    state_nxt    = sagc_pkg::SAGC_WAKING; // RULE7
                    hold_cnt_nxt = sagc_pkg::HOLD_START;
                end
            end
            sagc_pkg::SAGC_WAKING: begin
                // Gate enables need one rising and one falling edge to settle
                if (hold_cnt_r == sagc_pkg::HOLD_LAST) begin
                    state_nxt = sagc_pkg::SAGC_AWAKE;
                end
                hold_cnt_nxt = hold_cnt_r - 2'h1;
            end
            default: begin
                state_nxt = sagc_pkg::SAGC_AWAKE;
            end
        endcase
    end

    // State and wake counter
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r    <= sagc_pkg::SAGC_AWAKE;
            hold_cnt_r <= 2'h0;
        end else begin
            state_r    <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // ********************************
    // Mask selection and gates
    // ********************************
    sagc_pkg::sagc_mask_t active_mask_r;
    wire                  sel_sleep;
    sagc_pkg::sagc_mask_t active_mask_nxt;

    // Sleep mask rules only in the sleep state, awake mask otherwise RULE5 RULE8
    assign sel_sleep       = (state_r == sagc_pkg::SAGC_SLEEP);
    assign active_mask_nxt = sel_sleep ? sleep_clock_mask_r : awake_clock_mask_r;

    // Registered so gate enables never see decode hazards
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            active_mask_r <= sagc_pkg::MASK_RESET;
        end else begin
            active_mask_r <= active_mask_nxt;
        end
    end

    // One gate per endpoint; processor clocks are not among them RULE1 RULE11
    for (genvar g = 0; g < sagc_pkg::ENDPOINTS; g++) begin : gen_gate
        sagc_gate_cell u_gate (
            .clk_in    (clk_in),
            .reset_in  (reset_in),
            .enable_in (active_mask_r[g]),
            .gclk_out  (gclk_out[g])
        );
    end

    // ********************************
    // Outputs
    // ********************************
    // Clock request: hold the bus until re-enabled clocks run RULE10
    assign bus_hold_out         = (state_r == sagc_pkg::SAGC_WAKING);
    assign in_sleep_out         = sel_sleep;
    assign awake_clock_mask_out = awake_clock_mask_r;
    assign sleep_clock_mask_out = sleep_clock_mask_r;
    assign active_mask_out      = active_mask_r;

    // ********************************
    // Checks
    // ********************************
    sequence wake_seen_s;
        sel_sleep && wake_req;
    endsequence

    sequence hold_run_s;
        bus_hold_out [*2] ##1 !bus_hold_out;
    endsequence

    mask_reset_a: assert property ( // RULE13
        @(posedge clk_in) $past(reset_in) && !reset_in |->
            awake_clock_mask_r == sagc_pkg::MASK_RESET && sleep_clock_mask_r == sagc_pkg::MASK_RESET)
        else $error("Masks not all ones after reset");

    mask_load_a: assert property ( // RULE9
        @(posedge clk_in) disable iff (reset_in)
        awake_wr_in.load && !sleep_wr_in.load |=>
            awake_clock_mask_r == $past(awake_wr_in.value) && $stable(sleep_clock_mask_r))
        else $error("Awake mask load wrong or disturbed sleep mask");

    sleep_entry_a: assert property ( // RULE6
        @(posedge clk_in) disable iff (reset_in)
        state_r == sagc_pkg::SAGC_AWAKE && sleep_ok && !wake_req |=> in_sleep_out)
        else $error("Sleep not entered when allowed");

    sleep_guard_a: assert property ( // RULE6
        @(posedge clk_in) disable iff (reset_in)
        $rose(in_sleep_out) |-> $past(sleep_ok))
        else $error("Sleep entered without both cores asleep and DMA idle");

    wake_exit_a: assert property ( // RULE7
        @(posedge clk_in) disable iff (reset_in)
        wake_seen_s |=> !in_sleep_out)
        else $error("Sleep not left on wake interrupt");

    awake_sel_a: assert property ( // RULE5
        @(posedge clk_in) disable iff (reset_in)
        !sel_sleep |=> active_mask_r == $past(awake_clock_mask_r))
        else $error("Awake mask not applied");

    sleep_sel_a: assert property ( // RULE8
        @(posedge clk_in) disable iff (reset_in)
        sel_sleep |=> active_mask_r == $past(sleep_clock_mask_r))
        else $error("Sleep mask not applied");

    wake_hold_a: assert property ( // RULE10
        @(posedge clk_in) disable iff (reset_in)
        wake_seen_s |=> hold_run_s)
        else $error("Bus hold after wake not two cycles");

    hold_release_a: assert property ( // RULE10
        @(posedge clk_in) disable iff (reset_in)
        $fell(bus_hold_out) |-> active_mask_r == $past(awake_clock_mask_r, 2)
            || $past(awake_wr_in.load, 2))
        else $error("Bus released before awake clocks applied");

    // Only a wake interrupt may end sleep, so the sleep mask keeps ruling
    sleep_hold_a: assert property ( // RULE8
        @(posedge clk_in) disable iff (reset_in)
        sel_sleep && !wake_req |=> sel_sleep)
        else $error("Sleep left without a wake interrupt");

    // While the bus is held the block is waking and cannot fall back asleep
    hold_no_sleep_a: assert property ( // RULE10
        @(posedge clk_in) disable iff (reset_in)
        bus_hold_out |=> !sel_sleep)
        else $error("Sleep entered while bus still held");

endmodule

`default_nettype wire

// *** design/sagc_gate_cell.sv ***
// One glitch-free clock gate for a single endpoint.
// Assumes the enable is launched by rising edges of the same clock.
`timescale 1ns/1ps
`default_nettype none

module sagc_gate_cell (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Control
    input  wire logic enable_in,
    // Gated clock
    output logic      gclk_out
);

    logic en_low_r;

    // Enable moves only while the clock is low, so no runt high phase RULE2
    always_ff @(negedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            en_low_r <= 1'b1;
        end else begin
            en_low_r <= enable_in;
        end
    end

    // Clock only stops; endpoint logic is never reset here RULE3
    assign gclk_out = clk_in & en_low_r;

endmodule

`default_nettype wire

// *** design/sagc_pkg.sv ***
// Shared constants and types for the sleep aware clock gating block.
// Assumes one system clock and endpoints gated from that same clock.
package sagc_pkg;

    // ********************************
    // Sizes, reset values and timing
    // ********************************
    localparam int unsigned ENDPOINTS      = 8;
    localparam logic [7:0]  MASK_RESET     = 8'hFF;
    localparam int unsigned WAKE_HOLD_CYC  = 2;
    localparam logic [1:0]  HOLD_LAST      = 2'h1;
    localparam logic [1:0]  HOLD_START     = 2'(WAKE_HOLD_CYC);

    // ********************************
    // Types
    // ********************************
    typedef logic [ENDPOINTS-1:0] sagc_mask_t;

    // Status from the processors and the DMA engine
    typedef struct packed {
        logic [1:0] proc_asleep;
        logic [1:0] proc_wake_irq;
        logic       dma_busy;
    } sagc_status_t;

    // Mask load request, one per mask set
    typedef struct packed {
        logic       load;
        sagc_mask_t value;
    } sagc_mask_wr_t;

    typedef enum logic [1:0] {
        SAGC_AWAKE,
        SAGC_SLEEP,
        SAGC_WAKING
    } sagc_state_t;

endpackage
